//--- psd_pkg.sv
package psd_pkg;
  localparam int SR_W     = 17;
  localparam int SWAL_W   = 7;
  localparam int PROG_W   = 10;
  localparam int REF_W    = 11;
  localparam int SWAL_LSB = 0;
  localparam int PROG_LSB = 7;
  localparam logic [SR_W-1:0]  LATCH_RST   = 17'h00800;
  localparam logic [PROG_W-1:0] PROG_MIN   = 10'h010;
  localparam logic [REF_W-1:0] REF_DIV_LUT [8] = '{
    11'h007, 11'h00F, 11'h03F, 11'h07F, 11'h0FF, 11'h1FF, 11'h3FF, 11'h7FF
  };
  localparam logic [11:0] REF_DIV_MAX = 12'h800;
endpackage

//--- psd_sync2.sv
`timescale 1ns/10ps
module psd_sync2 #(
  parameter int W = 1
) (
  // clock
  input  wire logic         clk,
  input  wire logic         ce,
  // data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] stage1_ff;

  always_ff @(posedge clk) begin
    if (ce) begin
      stage1_ff <= din;
      dout      <= stage1_ff;
    end
  end
endmodule // psd_sync2

//--- psd_serial_pll_synth_divider.sv
`timescale 1ns/10ps
// Summary of operation
// RULE1: shift one serial bit per serial rising edge
// RULE2: load strobe high copies shifter into latch
// RULE3: divider from 7-bit swallow, 10-bit counter
// RULE4: swallow 0-127, counter 16-1023, ref 8-2048
// RULE5: modulus select changes on feedback falling edge; the modSel pin changes on the core_clk rising edge instead
// RULE6: prescaler low modulus when select high
// RULE7: lock output high when locked, else low pulses
// RULE8: charge pump up, float, or down
// RULE9: two pump outputs for external charge pump
// RULE10: three selects choose eight reference ratios
// RULE11: feedback input clocks the programmable divider
// RULE12: host sends most significant bit first
// RULE13: vco equals (N times M plus A) times ref
// RULE14: select low A pulses, high rest, reload
module psd_serial_pll_synth_divider (
  // core clock
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic clkEn,
  // serial load link
  input  wire logic serClk,
  input  wire logic serData,
  input  wire logic load_strobe,
  // feedback divider clock domain
  input  wire logic fbClk,
  // reference selects
  input  wire logic ref_ratio_sel0,
  input  wire logic ref_ratio_sel1,
  input  wire logic ref_ratio_sel2,
  // outputs
  output logic      modSel,
  output logic      lock_indicator_out,
  output logic      pumpOut,
  output logic      pumpOutEn_n,
  output logic      pumpUpOut,
  output logic      pumpDnOut,
  output logic      ref_compare_freq,
  output logic      div_compare_freq
);
  logic [psd_pkg::SR_W-1:0]   shift_ff;
  logic [psd_pkg::SR_W-1:0]   latch_ff;
  logic [2:0]                 selSync;
  logic                       strobeSync;
  logic [psd_pkg::SR_W-1:0]   shiftSync;
  logic [psd_pkg::SWAL_W-1:0] swalCnt_ff;
  logic [psd_pkg::PROG_W-1:0] progCnt_ff;
  logic [psd_pkg::SR_W-1:0]   latchFbSync;
  logic                       fbTog_ff;
  logic                       fbTogSync;
  logic                       fbTogPrev_ff;
  logic                       fbPulse;
  logic                       modSelFb_ff;
  logic                       fbRst;
  logic [psd_pkg::REF_W-1:0]  refCnt_ff;
  logic                       refPulse;
  logic                       upReq_ff;
  logic                       dnReq_ff;
  logic [psd_pkg::PROG_W-1:0] progLoad;
  logic                       modSelSync;

  // serial shifter on the link clock, msb enters first and ends at bit 16
  always_ff @(posedge serClk) begin
    shift_ff <= {shift_ff[psd_pkg::SR_W-2:0], serData}; // see RULE1 see RULE12
  end

  // shifter word is held stable by the host while the strobe is high
  psd_sync2 #(.W(psd_pkg::SR_W)) u_shSync (
    .clk (core_clk), .ce (clkEn), .din (shift_ff), .dout (shiftSync)
  );
  psd_sync2 #(.W(1)) u_stbSync (
    .clk (core_clk), .ce (clkEn), .din (load_strobe), .dout (strobeSync)
  );
  psd_sync2 #(.W(3)) u_selSync (
    .clk (core_clk), .ce (clkEn),
    .din ({ref_ratio_sel2, ref_ratio_sel1, ref_ratio_sel0}), .dout (selSync)
  );

  always_ff @(posedge core_clk) begin
    if (srst) begin
      latch_ff <= psd_pkg::LATCH_RST;
    end else if (clkEn && strobeSync) begin
      latch_ff <= shiftSync; // see RULE2
    end
  end

  // latch and reset cross into the feedback domain as quasi-static levels
  psd_sync2 #(.W(psd_pkg::SR_W)) u_latFb (
    .clk (fbClk), .ce (1'b1), .din (latch_ff), .dout (latchFbSync)
  );
  psd_sync2 #(.W(1)) u_rstFb (
    .clk (fbClk), .ce (1'b1), .din (srst), .dout (fbRst)
  );

  // counts below the minimum are clamped so the divider never stalls
  always_comb begin
    progLoad = latchFbSync[psd_pkg::PROG_LSB +: psd_pkg::PROG_W];
    if (progLoad < psd_pkg::PROG_MIN) begin
      progLoad = psd_pkg::PROG_MIN; // see RULE4
    end
  end

  // pulse swallow divider, one count per prescaler output pulse
  always_ff @(posedge fbClk) begin
    if (fbRst) begin
      swalCnt_ff <= '0;
      progCnt_ff <= psd_pkg::PROG_MIN;
      fbTog_ff   <= 1'b0;
    end else if (progCnt_ff <= 10'h001) begin
      swalCnt_ff <= latchFbSync[psd_pkg::SWAL_LSB +: psd_pkg::SWAL_W]; // see RULE3 see RULE14
      progCnt_ff <= progLoad; // see RULE11
      fbTog_ff   <= ~fbTog_ff;
    end else begin
      progCnt_ff <= progCnt_ff - 10'h001; // see RULE13
      if (swalCnt_ff != '0) begin
        swalCnt_ff <= swalCnt_ff - 7'h01;
      end
    end
  end

  // select updates on the falling edge; low while swallowing
  always_ff @(negedge fbClk) begin
    if (fbRst) begin
      modSelFb_ff <= 1'b1;
    end else begin
      modSelFb_ff <= (swalCnt_ff == '0); // see RULE5 see RULE6 see RULE14
    end
  end

  psd_sync2 #(.W(1)) u_modSync (
    .clk (core_clk), .ce (clkEn), .din (modSelFb_ff), .dout (modSelSync)
  );
  psd_sync2 #(.W(1)) u_togSync (
    .clk (core_clk), .ce (clkEn), .din (fbTog_ff), .dout (fbTogSync)
  );

  // the pin output is retimed to core_clk; a fast prescaler wants it raw
  always_ff @(posedge core_clk) begin
    if (srst) begin
      modSel <= 1'b1;
    end else if (clkEn) begin
      modSel <= modSelSync;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      fbTogPrev_ff <= 1'b0;
    end else if (clkEn) begin
      fbTogPrev_ff <= fbTogSync;
    end
  end
  assign fbPulse = fbTogSync ^ fbTogPrev_ff;

  // reference divider; table holds terminal counts so a ratio of 2048 fits 11 bits
  always_ff @(posedge core_clk) begin
    if (srst) begin
      refCnt_ff <= '0;
    end else if (clkEn) begin
      if (refCnt_ff >= psd_pkg::REF_DIV_LUT[selSync]) begin
        refCnt_ff <= '0; // see RULE10
      end else begin
        refCnt_ff <= refCnt_ff + 11'h001;
      end
    end
  end
  assign refPulse = (refCnt_ff == '0);

  // phase frequency detector; a tie in one cycle cancels both requests
  always_ff @(posedge core_clk) begin
    if (srst) begin
      upReq_ff <= 1'b0;
      dnReq_ff <= 1'b0;
    end else if (clkEn) begin
      if ((upReq_ff || refPulse) && (dnReq_ff || fbPulse)) begin
        upReq_ff <= 1'b0;
        dnReq_ff <= 1'b0;
      end else begin
        upReq_ff <= upReq_ff | refPulse;
        dnReq_ff <= dnReq_ff | fbPulse;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pumpOut            <= 1'b0;
      pumpOutEn_n        <= 1'b1;
      pumpUpOut          <= 1'b1;
      pumpDnOut          <= 1'b0;
      lock_indicator_out <= 1'b1;
      ref_compare_freq   <= 1'b0;
      div_compare_freq   <= 1'b0;
    end else if (clkEn) begin
      pumpOut            <= upReq_ff; // see RULE8
      pumpOutEn_n        <= ~(upReq_ff ^ dnReq_ff); // see RULE8
      pumpUpOut          <= ~upReq_ff; // see RULE9
      pumpDnOut          <= dnReq_ff; // see RULE9
      lock_indicator_out <= ~(upReq_ff ^ dnReq_ff); // see RULE7
      ref_compare_freq   <= refPulse;
      div_compare_freq   <= fbPulse;
    end
  end
endmodule // psd_serial_pll_synth_divider

//--- psd_host.sv
`timescale 1ns/10ps
module psd_host (
  input  wire logic core_clk,
  output logic      serClk, serData, load_strobe
);
  initial {serClk, serData, load_strobe} = 3'h0;
  // link clock only runs inside a frame; data flips afterwards so a stale bit never looks valid
  task automatic load(input logic [16:0] w);
    for (int i = 16; i >= 0; i--) begin
      #17 serData = w[i];
      #23 serClk = 1'b1;
      #40 serClk = 1'b0;
    end
    #7 serData = ~serData;
    @(posedge core_clk) #1 load_strobe = 1'b1;
    repeat (4) @(posedge core_clk);
    #1 load_strobe = 1'b0;
  endtask
endmodule // psd_host

//--- psd_props.sv
`timescale 1ns/10ps
module psd_props (
  input wire logic core_clk, srst, modSel, lock_indicator_out, pumpOut, pumpOutEn_n,
  input wire logic pumpUpOut, pumpDnOut, ref_compare_freq, div_compare_freq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  a_reset_outs: assert property (disable iff (1'b0) srst [*8] |-> modSel &&
    lock_indicator_out && pumpOutEn_n && pumpUpOut && !pumpDnOut) else $error("reset levels");
  a_ref_single: assert property (ref_compare_freq |=> !ref_compare_freq)
    else $error("ref pulse long");
  a_ref_spacing: assert property (ref_compare_freq |=> !ref_compare_freq [*7])
    else $error("ref too close");
  a_div_single: assert property (div_compare_freq |=> !div_compare_freq)
    else $error("div pulse long");
  a_pump_excl: assert property (pumpUpOut || !pumpDnOut) else $error("up and down");
  a_pump_float: assert property (pumpOutEn_n |-> pumpUpOut && !pumpDnOut)
    else $error("request while floating");
  a_pump_dir: assert property (!pumpOutEn_n |->
    pumpOut != pumpUpOut && pumpOut != pumpDnOut) else $error("pump direction");
  a_lock_pump: assert property (lock_indicator_out == pumpOutEn_n) else $error("lock");
  c_lock_low: cover property (!lock_indicator_out);
  c_div_ev: cover property (div_compare_freq);
  c_mod_low: cover property (!modSel);
endmodule // psd_props
bind psd_serial_pll_synth_divider psd_props u_psd_props (.*);

//--- tb_top.sv
`timescale 1ns/10ps
module tb_top;
  localparam logic [16:0] WORDS [3] = '{{10'h014, 7'h06}, {10'h005, 7'h00}, {10'h3FF, 7'h7F}};
  logic core_clk = 1'b0, fbClk = 1'b0, srst = 1'b1, clkEn = 1'b1;
  logic ref_ratio_sel0 = 1'b0, ref_ratio_sel1 = 1'b0, ref_ratio_sel2 = 1'b0;
  logic serClk, serData, load_strobe, modSel, lock_indicator_out, pumpOut, pumpOutEn_n;
  logic pumpUpOut, pumpDnOut, ref_compare_freq, div_compare_freq;
  int   fails = 0, comparisons = 0;
  always #50 core_clk = ~core_clk;
  // prescaler output stand-in; one divide count is half a core cycle, so checks allow jitter
  always #25 fbClk = ~fbClk;
  psd_host u_psd_host (.*);
  psd_serial_pll_synth_divider u_psd_serial_pll_synth_divider (.*);
  task automatic end_sim;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic seen, input logic exp);
    comparisons++;
    fails += int'(seen !== exp);
    if (seen !== exp) $display("Error at %0t: mismatch", $time);
  endtask
  task automatic gap(input bit d, output int n, output int lo);
    {n, lo} = '0;
    do begin
      @(negedge core_clk);
      n++;
      lo += int'(!modSel);
    end while (!(d ? div_compare_freq : ref_compare_freq));
  endtask
  task automatic t_ref;
    int n, lo;
    for (int c = 0; c < 8; c++) begin
      @(posedge core_clk) #1 {ref_ratio_sel2, ref_ratio_sel1, ref_ratio_sel0} = c[2:0];
      repeat (3) gap(1'b0, n, lo);
      chk(n == (c < 2 ? 8 << c : 16 << c), 1'b1);
    end
    $display("t_ref done");
  endtask
  task automatic t_div;
    int n, lo, nf;
    for (int k = 0; k < 3; k++) begin
      u_psd_host.load(WORDS[k]);
      repeat (3) gap(1'b1, n, lo);
      nf = WORDS[k][16:7] < 16 ? 16 : WORDS[k][16:7];
      chk(n * 2 - nf inside {[-3:3]}, 1'b1);
      chk(lo * 2 - int'(WORDS[k][6:0]) inside {[-3:3]}, 1'b1);
    end
    $display("t_div done");
  endtask
  task automatic t_pump;
    int up, dn, pu, pd, lk;
    for (int c = 0; c < 2; c++) begin
      @(posedge core_clk) #1 {ref_ratio_sel2, ref_ratio_sel1, ref_ratio_sel0} = c ? 3'h7 : 3'h0;
      repeat (600) @(posedge core_clk);
      {up, dn, pu, pd, lk} = '0;
      repeat (600) @(negedge core_clk) begin
        up += int'(!pumpOutEn_n && pumpOut);
        dn += int'(!pumpOutEn_n && !pumpOut);
        pu += int'(!pumpUpOut);
        pd += int'(pumpDnOut);
        lk += int'(!lock_indicator_out);
      end
      chk(up > 0, c == 0);
      chk(dn > 0, c == 1);
      chk(pu > 0, c == 0);
      chk(pd > 0, c == 1);
      chk(lk > 0, 1'b1);
    end
    $display("t_pump done");
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    #1 srst = 1'b0;
    t_ref();
    t_div();
    t_pump();
    end_sim();
  end
  initial begin
    #5000000 fails++;
    end_sim();
  end
endmodule // tb_top
